// File: sim/pssi_port_top_tb.sv
// Purpose: Self-checking bench for the port supply select and init block.
// Assumes: APB slave answers within a few cycles; the bench drives all pads.
// Notes: Port D present; stimulus is fixed, with no random values.

`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module pssi_port_top_tb import pssi_pkg::*; ;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, sleep, wake, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NPORT*PW-1:0] pad, pad_out, pad_oe;
  logic [NSUP-1:0] sup_io, sup_reg;
  int err_count, n_checks;

  pssi_port_top pssi_port_top_i (
    .I_CLK_SYS(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PRDATA(prdata),
    .I_PAD_IN(pad), .O_PAD_OUT(pad_out), .O_PAD_OE(pad_oe),
    .I_SLEEP_IDLE(sleep), .O_WAKE_REQ(wake), .O_IRQ(irq),
    .O_SUP_IO_SEL(sup_io), .O_SUP_REG_SEL(sup_reg)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run();
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] seen,
                     input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A transfer holds every request signal until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, a, d, v, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic e;
    apb(1'b0, a, 32'h0, v, e);
    chk("read data", v, exp);
  endtask

  function automatic logic [11:0] sel_of(input logic [23:0] all,
                                         input logic [1:0] code);
    for (int k = 0; k < 12; k++)
      sel_of[k] = (all[2*k+:2] == code);
  endfunction

  task automatic t_reset();
    chk("pad_out", pad_out, {40{1'b1}});
    chk("pad_oe", pad_oe, 40'h0);
    chk("sup_sel", {sup_io, sup_reg}, 40'h0);
    rdchk(OFS_DATA, 32'h0);
    for (int p = 0; p < 5; p++)
      rdchk(OFS_DIR + 8'(4*p), 32'hFF);
    for (int s = 0; s < 3; s++)
      rdchk(OFS_SUP_AL + 8'(4*s), 32'h0);
  endtask

  // Walk every code through every pin field; earlier fields stay set.
  task automatic t_supply();
    logic [23:0] all;
    logic [7:0] a;
    all = 24'h0;
    for (int k = 0; k < 12; k++)
      for (int c = 0; c < 4; c++) begin
        all[2*k+:2] = 2'(c);
        a = OFS_SUP_AL + 8'(4*(k/4));
        wr(a, {24'h0, all[8*(k/4)+:8]});
        @(negedge clk);
        chk("sup_io", sup_io, sel_of(all, PSSI_SUP_IO));
        chk("sup_reg", sup_reg, sel_of(all, PSSI_SUP_REG));
        rdchk(a, {24'h0, all[8*(k/4)+:8]});
      end
  endtask

  task automatic t_output();
    wr(OFS_DIR, 32'hF0);
    @(negedge clk);
    chk("oe_a", pad_oe[7:0], 8'h0F);
    chk("out_a", pad_out[7:0], 8'hFF);
    rdchk(OFS_DATA, 32'h0F);
    wr(OFS_BITOP, 32'h000);
    @(negedge clk);
    chk("out_a", pad_out[7:0], 8'h0E);
    wr(OFS_BITOP, 32'h112);
    rdchk(OFS_DIR + 8'h04, 32'hFB);
    chk("oe_b", pad_oe[15:8], 8'h04);
    wr(OFS_BITOP, 32'h312);
    rdchk(OFS_DIR + 8'h04, 32'hFF);
  endtask

  task automatic toggle_wait(input int pin, output logic got);
    @(posedge clk);
    pad[pin] <= ~pad[pin];
    got = 1'b0;
    repeat (8) begin
      @(posedge clk);
      got = got | (wake === 1'b1);
    end
  endtask

  task automatic t_wake();
    int pins[4] = '{5, 6, 13, 9};
    logic exp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic got;
    wr(OFS_MASK, 32'h1);
    wr(OFS_WAKE_A, 32'h20);
    wr(OFS_WAKE_N, 32'h02);
    sleep <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      toggle_wait(pins[i], got);
      chk("wake", got, exp[i]);
    end
    rdchk(OFS_STAT, 32'h1);
    chk("irq", irq, 1'b1);
    wr(OFS_STAT, 32'h1);
    @(negedge clk);
    chk("irq", irq, 1'b0);
    sleep <= 1'b0;
    toggle_wait(5, got);
    chk("wake", got, 1'b0);
    wr(OFS_MASK, 32'h0);
    sleep <= 1'b1;
    toggle_wait(13, got);
    chk("wake", got, 1'b1);
    chk("irq", irq, 1'b0);
    rdchk(OFS_STAT, 32'h1);
  endtask

  task automatic t_unmapped();
    logic [31:0] v;
    logic e;
    apb(1'b0, 8'h7C, 32'h0, v, e);
    chk("slverr", e, 1'b1);
    chk("read data", v, 32'h0);
  endtask

  initial begin
    err_count = 0;
    n_checks = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pad = '0;
    sleep = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_supply();
    t_output();
    t_wake();
    t_unmapped();
    complete_run();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    #160000;
    err_count++;
    complete_run();
  end
endmodule

`default_nettype wire

// File: verilog/pssi_pkg.sv
// Purpose: Constants and types for the port supply select and init block.
// Assumes: APB slave with 32-bit data and byte addresses.
// Notes: Five 8-bit ports, index 0 to 4 standing for ports A to E.

// ----------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------
package pssi_pkg;
  localparam int NPORT = 5;
  localparam int PW = 8;
  localparam int NSUP = 12;
  localparam logic [2:0] PORT_D_IDX = 3'h3;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h20;
  localparam logic [7:0] OFS_BITOP = 8'h40;
  localparam logic [7:0] OFS_WAKE_A = 8'h44;
  localparam logic [7:0] OFS_WAKE_N = 8'h48;
  localparam logic [7:0] OFS_SUP_AL = 8'h50;
  localparam logic [7:0] OFS_SUP_AH = 8'h54;
  localparam logic [7:0] OFS_SUP_DH = 8'h58;
  localparam logic [7:0] OFS_STAT = 8'h60;
  localparam logic [7:0] OFS_MASK = 8'h64;
  localparam logic [2:0] GRP_DATA = 3'h0;
  localparam logic [2:0] GRP_DIR = 3'h1;
  localparam logic [7:0] RST_LATCH = 8'hFF;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_SUP = 8'h00;
  localparam logic [7:0] RST_WAKE = 8'h00;
  localparam int BOP_BIT_LSB = 0;
  localparam int BOP_PORT_LSB = 4;
  localparam int BOP_DIR_POS = 8;
  localparam int BOP_SET_POS = 9;
  localparam int STAT_WAKE_POS = 0;
  typedef enum logic [1:0] {
    PSSI_SUP_MAIN0 = 2'b00,
    PSSI_SUP_MAIN1 = 2'b01,
    PSSI_SUP_IO = 2'b10,
    PSSI_SUP_REG = 2'b11
  } pssi_sup_t;
endpackage

// File: verilog/pssi_port_top.sv
// Purpose: Port data, direction, wake-up and pad supply select logic.
// Assumes: Pads are sampled asynchronously; sleep flag is on I_CLK_SYS.
// Notes: APB answers with no wait states; read data comes from a flop.

`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Top module
// ----------------------------------------------------------------------
// How it works
// R1 - Codes 00/01 main, 10 io rail, 11 regulator.
// R2 - Low A register holds pins 0 to 3.
// R3 - High A register holds pins 4 to 7.
// R4 - Port D register holds pins 4 to 7.
// R5 - Every pin field is independent.
// R6 - Reset sets data and direction bits high.
// R7 - Untouched latch drives high when made output.
// R8 - Bit set/clear reads port, rewrites whole byte.
// R9 - Direction takes byte writes and bit ops.
// R10 - Wake enable per pin A, nibble others.
// R11 - Enabled pin change in sleep requests wake.
// R12 - Direction zero outputs, one reads pin.
// R13 - Output pin reads back its latch.
// R14 - Supply selects are registered outputs.
module pssi_port_top import pssi_pkg::*; #(
  parameter bit P_HAS_PORT_D = 1'b1
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [31:0] O_PRDATA,
  input wire logic [NPORT*PW-1:0] I_PAD_IN,
  output logic [NPORT*PW-1:0] O_PAD_OUT,
  output logic [NPORT*PW-1:0] O_PAD_OE,
  input wire logic I_SLEEP_IDLE,
  output logic O_WAKE_REQ,
  output logic O_IRQ,
  output logic [NSUP-1:0] O_SUP_IO_SEL,
  output logic [NSUP-1:0] O_SUP_REG_SEL
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  function automatic logic [1:0] sup_dec(input logic [1:0] code);
    sup_dec = {code == PSSI_SUP_REG, code == PSSI_SUP_IO};
  endfunction

  logic [NPORT*PW-1:0] pin_s1_r, pin_s2_r, pin_prev_r, wake_en, trans;
  logic [NPORT-1:0][PW-1:0] latch_r, latch_nxt, dir_r, dir_nxt, rd_mix;
  logic [PW-1:0] wake_a_r, wake_n_r;
  logic [3*PW-1:0] sup_r, sup_nxt;
  logic [NSUP-1:0] io_nxt, reg_nxt;
  logic [31:0] prdata_r, rdata;
  logic wake_r, stat_r, stat_nxt, mask_r;
  logic [NSUP-1:0] sup_io_r, sup_reg_r;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire acc = I_PSEL & I_PENABLE;
  wire wr = acc & I_PWRITE;
  wire setup = I_PSEL & ~I_PENABLE;
  wire [2:0] pidx = I_PADDR[4:2];
  wire pidx_ok = pidx < 3'(NPORT);
  wire hit_data = (I_PADDR[7:5] == GRP_DATA) & pidx_ok;
  wire hit_dir = (I_PADDR[7:5] == GRP_DIR) & pidx_ok;
  wire hit_bop = I_PADDR == OFS_BITOP;
  wire hit_wa = I_PADDR == OFS_WAKE_A;
  wire hit_wn = I_PADDR == OFS_WAKE_N;
  wire hit_sal = I_PADDR == OFS_SUP_AL;
  wire hit_sah = I_PADDR == OFS_SUP_AH;
  wire hit_sdh = (I_PADDR == OFS_SUP_DH) & P_HAS_PORT_D;
  wire hit_stat = I_PADDR == OFS_STAT;
  wire hit_mask = I_PADDR == OFS_MASK;
  wire hit = hit_data | hit_dir | hit_bop | hit_wa | hit_wn | hit_sal |
             hit_sah | hit_sdh | hit_stat | hit_mask;

  assign O_PREADY = acc;
  assign O_PSLVERR = acc & ~hit;
  assign O_PRDATA = prdata_r;

  // --------------------------------------------------------------------
  // Bit set and clear
  // --------------------------------------------------------------------
  // The data latch is rebuilt from the mixed read value, so an input
  // pin's latch picks up the pin level, just as a real RMW would.
  wire [2:0] bop_port = I_PWDATA[BOP_PORT_LSB +: 3];
  wire [2:0] bop_bit = I_PWDATA[BOP_BIT_LSB +: 3];
  wire bop_dir = I_PWDATA[BOP_DIR_POS];
  wire bop_set = I_PWDATA[BOP_SET_POS];
  wire bop_go = wr & hit_bop & (bop_port < 3'(NPORT));
  wire [PW-1:0] bop_mask = PW'(1) << bop_bit;
  wire [PW-1:0] bop_base = bop_dir ? dir_r[bop_port] : rd_mix[bop_port];
  wire [PW-1:0] bop_val = bop_set ? (bop_base | bop_mask) : // R8
                          (bop_base & ~bop_mask);

  always_comb begin
    latch_nxt = latch_r;
    dir_nxt = dir_r;
    if (wr & hit_data) begin
      latch_nxt[pidx] = I_PWDATA[PW-1:0];
    end
    if (wr & hit_dir) begin
      dir_nxt[pidx] = I_PWDATA[PW-1:0]; // R9
    end
    if (bop_go & bop_dir) begin
      dir_nxt[bop_port] = bop_val; // R9
    end
    if (bop_go & ~bop_dir) begin
      latch_nxt[bop_port] = bop_val; // R8
    end
  end

  // --------------------------------------------------------------------
  // Per-port pin mixing and wake enables
  // --------------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      assign rd_mix[gp] = (dir_r[gp] & pin_s2_r[gp*PW +: PW]) | // R12
                          (~dir_r[gp] & latch_r[gp]); // R13
      assign O_PAD_OUT[gp*PW +: PW] = latch_r[gp]; // R7
      assign O_PAD_OE[gp*PW +: PW] = ~dir_r[gp]; // R12
      if (gp == 0) begin : g_pin
        assign wake_en[PW-1:0] = wake_a_r; // R10
      end else begin : g_nib
        assign wake_en[gp*PW +: 4] = {4{wake_n_r[2*gp-2]}}; // R10
        assign wake_en[gp*PW+4 +: 4] = {4{wake_n_r[2*gp-1]}}; // R10
      end
    end
  endgenerate

  assign trans = pin_s2_r ^ pin_prev_r;
  wire wake_hit = I_SLEEP_IDLE & (|(trans & wake_en)); // R11

  // --------------------------------------------------------------------
  // Supply select
  // --------------------------------------------------------------------
  always_comb begin
    sup_nxt = sup_r;
    if (wr & hit_sal) begin
      sup_nxt[7:0] = I_PWDATA[7:0]; // R2
    end
    if (wr & hit_sah) begin
      sup_nxt[15:8] = I_PWDATA[7:0]; // R3
    end
    if (wr & hit_sdh) begin
      sup_nxt[23:16] = I_PWDATA[7:0]; // R4
    end
  end

  genvar gs;
  generate
    for (gs = 0; gs < NSUP; gs++) begin : g_sup
      assign {reg_nxt[gs], io_nxt[gs]} = sup_dec(sup_nxt[2*gs +: 2]); // R1 R5
    end
  endgenerate

  // --------------------------------------------------------------------
  // Read mux and status
  // --------------------------------------------------------------------
  always_comb begin
    rdata = 32'h00000000;
    if (hit_data) begin
      rdata[PW-1:0] = rd_mix[pidx]; // R13
    end else if (hit_dir) begin
      rdata[PW-1:0] = dir_r[pidx];
    end else if (hit_wa) begin
      rdata[PW-1:0] = wake_a_r;
    end else if (hit_wn) begin
      rdata[PW-1:0] = wake_n_r;
    end else if (hit_sal) begin
      rdata[PW-1:0] = sup_r[7:0];
    end else if (hit_sah) begin
      rdata[PW-1:0] = sup_r[15:8];
    end else if (hit_sdh) begin
      rdata[PW-1:0] = sup_r[23:16];
    end else if (hit_stat) begin
      rdata[STAT_WAKE_POS] = stat_r;
    end else if (hit_mask) begin
      rdata[STAT_WAKE_POS] = mask_r;
    end
  end

  // A wake event in the clearing cycle survives the write of one.
  assign stat_nxt = wake_hit |
                    (stat_r & ~(wr & hit_stat & I_PWDATA[STAT_WAKE_POS]));
  assign O_IRQ = stat_r & mask_r;
  assign O_WAKE_REQ = wake_r;
  assign O_SUP_IO_SEL = sup_io_r;
  assign O_SUP_REG_SEL = sup_reg_r;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------

  always_ff @(posedge I_CLK_SYS) begin
    pin_s1_r <= I_PAD_IN;
    pin_s2_r <= pin_s1_r;
    pin_prev_r <= pin_s2_r;
    if (setup) begin
      prdata_r <= rdata;
    end
    if (I_RESET) begin
      latch_r <= {NPORT{RST_LATCH}}; // R6
      dir_r <= {NPORT{RST_DIR}}; // R6
      sup_r <= {3{RST_SUP}};
      sup_io_r <= '0;
      sup_reg_r <= '0;
      wake_a_r <= RST_WAKE;
      wake_n_r <= RST_WAKE;
      stat_r <= 1'b0;
      mask_r <= 1'b0;
      wake_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      latch_r <= latch_nxt;
      dir_r <= dir_nxt;
      sup_r <= sup_nxt;
      sup_io_r <= io_nxt; // R14
      sup_reg_r <= reg_nxt; // R14
      wake_a_r <= (wr & hit_wa) ? I_PWDATA[PW-1:0] : wake_a_r;
      wake_n_r <= (wr & hit_wn) ? I_PWDATA[PW-1:0] : wake_n_r;
      mask_r <= (wr & hit_mask) ? I_PWDATA[STAT_WAKE_POS] : mask_r;
      stat_r <= stat_nxt;
      wake_r <= wake_hit; // R11
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  logic lat_wr_seen_r;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      lat_wr_seen_r <= 1'b0;
    end else if ((wr & hit_data) | (bop_go & ~bop_dir)) begin
      lat_wr_seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);

  sequence s_bop_a;
    bop_go && !bop_dir && bop_port == 3'h0;
  endsequence
  sequence s_rd_a0;
    setup && !I_PWRITE && hit_data && pidx == 3'h0;
  endsequence

  property p_dec;
    ##1 O_SUP_IO_SEL[1] == (sup_r[3:2] == PSSI_SUP_IO) &&
        O_SUP_REG_SEL[1] == (sup_r[3:2] == PSSI_SUP_REG);
  endproperty
  a_dec: assert property (p_dec) else $error("supply decode wrong"); // R1
  property p_al;
    wr && hit_sal |=> O_SUP_REG_SEL[3] == (&$past(I_PWDATA[7:6]));
  endproperty
  a_al: assert property (p_al) else $error("pin a3 select wrong"); // R2
  property p_ah;
    wr && hit_sah |=> O_SUP_IO_SEL[4] == ($past(I_PWDATA[1:0]) == 2'b10);
  endproperty
  a_ah: assert property (p_ah) else $error("pin a4 select wrong"); // R3
  property p_pd;
    wr && hit_sdh |=> O_SUP_REG_SEL[11] == (&$past(I_PWDATA[7:6]));
  endproperty
  a_pd: assert property (p_pd) else $error("pin d7 select wrong"); // R4
  property p_indep;
    wr && hit_sal |=> sup_r[23:8] == $past(sup_r[23:8]);
  endproperty
  a_indep: assert property (p_indep) else $error("fields coupled"); // R5
  property p_reset;
    $fell(I_RESET) |-> (&O_PAD_OUT) && !(|O_PAD_OE);
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state"); // R6
  property p_fresh;
    !lat_wr_seen_r && O_PAD_OE[0] |-> O_PAD_OUT[0];
  endproperty
  a_fresh: assert property (p_fresh) else $error("fresh output low"); // R7
  property p_rmw;
    s_bop_a |=> ((latch_r[0] ^ $past(rd_mix[0])) & ~$past(bop_mask)) == 8'h00;
  endproperty
  a_rmw: assert property (p_rmw) else $error("rmw hit other bits"); // R8
  property p_dirb;
    wr && hit_dir && pidx == 3'h0 |=> O_PAD_OE[7:0] == ~$past(I_PWDATA[7:0]);
  endproperty
  a_dirb: assert property (p_dirb) else $error("direction write lost"); // R9
  property p_wake;
    I_SLEEP_IDLE && wake_n_r[1] && trans[13] |=> O_WAKE_REQ && stat_r;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed"); // R10 R11
  property p_rdin;
    (s_rd_a0 and dir_r[0][0]) |=> O_PRDATA[0] == $past(pin_s2_r[0]);
  endproperty
  a_rdin: assert property (p_rdin) else $error("input read wrong"); // R12
  property p_rdout;
    (s_rd_a0 and !dir_r[0][0]) |=> O_PRDATA[0] == $past(latch_r[0][0]);
  endproperty
  a_rdout: assert property (p_rdout) else $error("latch read wrong"); // R13
endmodule

`default_nettype wire
